// >>> core/cal_rtc_core.sv
// Purpose: Calendar real-time counter with drift correction and Avalon-MM registers
// Assumes: 20 MHz clk; crystal and RC clocks are sampled, not used as clocks
// Notes: Main crystal above 10 MHz aliases when sampled; trade for a single domain
// Operation
// - Source from main or slow crystal
// - Main crystal divided by prescale setting
// - Internal RC clock is third source
// - Source clock forwarded to LCD logic
// - Trim clock output for timer, pin
// - Counter keeps running in wait mode
// - Counter keeps running in stop mode
// - Enabled interrupt wakes from stop, wait
// - Debug freeze halts per halt bit
// - Normal reset clears three registers only
// - Enable bit starts and stops counter
// - Drift correction enable bit
// - Locked enable register ignores writes
// - 16-bit counter, modulo in byte registers
// - Seconds, minutes, hours calendar registers
// - 1 Hz tick, optionally drift corrected
// - Unlocked after reset, key reads zero
// - Prescaled 1 MHz divided by 32
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cal_rtc_core
  import cal_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Source clocks
  input wire logic main_crystal_clock,
  input wire logic slow_crystal_clock,
  input wire logic internal_rc_clock,
  // System state
  input wire logic debug_freeze,
  // Clock and event outputs
  output logic counter_source_clock,
  output logic trim_reference_output,
  output logic irq_request
);
  function automatic logic wr_hit(input logic go, input logic [3:0] a, input logic [3:0] r);
    wr_hit = go && (a == r);
  endfunction : wr_hit

  // Carry in bit 6, next value below
  function automatic logic [6:0] step6(input logic [5:0] v, input logic [5:0] last);
    step6 = (v >= last) ? 7'h40 : {1'h0, v + 6'h01};
  endfunction : step6

  logic por_rst;
  logic any_rst;
  assign por_rst = !por_n;
  assign any_rst = !por_n || !rst_n;

  logic main_rise;
  logic slow_level;
  logic slow_rise;
  logic rc_level;
  logic rc_rise;

  cal_edge_sync u_main_sync (.clk(clk), .rst_n(por_n), .async_in(main_crystal_clock),
    .level(), .rise(main_rise));
  cal_edge_sync u_slow_sync (.clk(clk), .rst_n(por_n), .async_in(slow_crystal_clock),
    .level(slow_level), .rise(slow_rise));
  cal_edge_sync u_rc_sync (.clk(clk), .rst_n(por_n), .async_in(internal_rc_clock),
    .level(rc_level), .rise(rc_rise));

  // Bus slave: one wait state on every access
  cal_bus_type bus_state;
  cal_bus_type next_bus_state;
  logic [31:0] next_readdata;
  logic [3:0] idx;
  logic [7:0] wdat;
  logic [7:0] rd_mux;
  logic wr_go;

  assign idx = avs_address[5:2];
  assign wdat = avs_writedata[7:0];
  assign wr_go = avs_write && (bus_state == BUS_ACK) && avs_byteenable[0] && rst_n;
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state == BUS_IDLE);

  always_comb begin
    case (bus_state)
      BUS_IDLE: next_bus_state = (avs_read || avs_write) ? BUS_ACK : BUS_IDLE;
      BUS_ACK: next_bus_state = BUS_IDLE;
      default: next_bus_state = BUS_IDLE;
    endcase
    next_readdata = avs_readdata;
    if (bus_state == BUS_IDLE && avs_read) begin
      next_readdata = {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge clk) begin
    if (any_rst) begin
      bus_state <= BUS_IDLE;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_state <= next_bus_state;
      avs_readdata <= next_readdata;
    end
  end

  // Power-on domain state
  logic counter_enable_bit;
  logic drift_correction_enable;
  logic [1:0] tick_source_select;
  logic [3:0] main_osc_prescale;
  logic [7:0] drift_correction_value;
  logic [15:0] modulo;
  logic [15:0] count;
  logic [5:0] seconds;
  logic [5:0] minutes;
  logic [4:0] hours;
  logic [3:0] ps_cnt;
  logic [4:0] post_cnt;
  logic next_counter_enable_bit;
  logic next_drift_correction_enable;
  logic [1:0] next_tick_source_select;
  logic [3:0] next_main_osc_prescale;
  logic [7:0] next_drift_correction_value;
  logic [15:0] next_modulo;
  logic [15:0] next_count;
  logic [5:0] next_seconds;
  logic [5:0] next_minutes;
  logic [4:0] next_hours;
  logic [3:0] next_ps_cnt;
  logic [4:0] next_post_cnt;
  logic next_trim_reference_output;
  // Normal domain state
  cal_lock_type key_state;
  cal_lock_type next_key_state;
  logic halt_in_debug;
  logic trim_output_select;
  logic [7:0] irq_en;
  logic [7:0] flags;
  logic next_halt_in_debug;
  logic next_trim_output_select;
  logic [7:0] next_irq_en;
  logic [7:0] next_flags;
  logic next_irq_request;
  // Tick path
  logic mhz_tick;
  logic src_tick;
  logic src_level;
  logic run;
  logic comp_period;
  logic [15:0] terminal;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;
  logic drift_tick;
  logic hz_level;
  logic [6:0] sec_step;
  logic [6:0] min_step;
  logic [6:0] hr_step;
  logic [1:0] key;
  logic [7:0] events;
  logic [7:0] clear;

  always_comb begin
    next_ps_cnt = ps_cnt;
    next_post_cnt = post_cnt;
    mhz_tick = 1'h0;
    if (main_rise) begin
      if (ps_cnt >= main_osc_prescale) begin
        next_ps_cnt = 4'h0;
        mhz_tick = 1'h1;
      end else begin
        next_ps_cnt = ps_cnt + 4'h1;
      end
    end
    if (mhz_tick) begin
      next_post_cnt = post_cnt + 5'h01;
    end
    case (tick_source_select)
      SRC_MAIN: begin
        src_tick = mhz_tick && (post_cnt == MAIN_POST_LAST);
        src_level = post_cnt[4];
      end
      SRC_SLOW: begin
        src_tick = slow_rise;
        src_level = slow_level;
      end
      SRC_RC: begin
        src_tick = rc_rise;
        src_level = rc_level;
      end
      default: begin
        src_tick = 1'h0;
        src_level = 1'h0;
      end
    endcase
    // Nothing here depends on wait or stop; only enable and debug gate it
    run = counter_enable_bit && !(debug_freeze && halt_in_debug);
    // The correction lands once a minute so its effect is averaged
    comp_period = drift_correction_enable && (seconds == 6'h00);
    terminal = comp_period
      ? modulo + {{8{drift_correction_value[7]}}, drift_correction_value} : modulo;
    // Compare with >= so a smaller modulo written late cannot run away
    sec_tick = run && src_tick && (count >= terminal);
    next_count = count;
    if (run && src_tick) begin
      next_count = sec_tick ? 16'h0000 : count + 16'h0001;
    end
    drift_tick = sec_tick && comp_period;
    hz_level = count < {1'h0, terminal[15:1]};
    sec_step = step6(seconds, SEC_LAST);
    min_step = step6(minutes, MIN_LAST);
    hr_step = step6({1'h0, hours}, HOUR_LAST);
    min_tick = sec_tick && sec_step[6];
    hour_tick = min_tick && min_step[6];
  end

  always_comb begin
    next_counter_enable_bit = counter_enable_bit;
    next_drift_correction_enable = drift_correction_enable;
    next_tick_source_select = tick_source_select;
    next_main_osc_prescale = main_osc_prescale;
    next_drift_correction_value = drift_correction_value;
    next_modulo = modulo;
    next_seconds = seconds;
    next_minutes = minutes;
    next_hours = hours;
    if (sec_tick) begin
      next_seconds = sec_step[5:0];
    end
    if (min_tick) begin
      next_minutes = min_step[5:0];
    end
    if (hour_tick) begin
      next_hours = hr_step[4:0];
    end
    if (wr_hit(wr_go, idx, IDX_ENABLE) && key_state == LK_OPEN) begin
      next_counter_enable_bit = wdat[BIT_COUNTER_ENABLE];
      next_drift_correction_enable = wdat[BIT_DRIFT_ENABLE];
    end
    if (wr_hit(wr_go, idx, IDX_CLOCK_SEL)) begin
      next_tick_source_select = wdat[7:6];
      next_main_osc_prescale = wdat[3:0];
    end
    if (wr_hit(wr_go, idx, IDX_DRIFT)) begin
      next_drift_correction_value = wdat;
    end
    if (wr_hit(wr_go, idx, IDX_MOD_HI)) begin
      next_modulo[15:8] = wdat;
    end
    if (wr_hit(wr_go, idx, IDX_MOD_LO)) begin
      next_modulo[7:0] = wdat;
    end
    // Software writes win over a tick in the same cycle
    if (wr_hit(wr_go, idx, IDX_SECONDS)) begin
      next_seconds = wdat[5:0];
    end
    if (wr_hit(wr_go, idx, IDX_MINUTES)) begin
      next_minutes = wdat[5:0];
    end
    if (wr_hit(wr_go, idx, IDX_HOURS)) begin
      next_hours = wdat[4:0];
    end
    // The LCD source also feeds the trim output unless trim select picks the 1 Hz level
    next_trim_reference_output = trim_output_select ? hz_level : src_level;
  end

  always_ff @(posedge clk) begin
    if (por_rst) begin
      counter_enable_bit <= 1'h0;
      drift_correction_enable <= 1'h0;
      tick_source_select <= SRC_MAIN;
      main_osc_prescale <= 4'h0;
      drift_correction_value <= REG_RESET;
      modulo <= 16'h0000;
      count <= 16'h0000;
      seconds <= 6'h00;
      minutes <= 6'h00;
      hours <= 5'h00;
      ps_cnt <= 4'h0;
      post_cnt <= 5'h00;
      counter_source_clock <= 1'h0;
      trim_reference_output <= 1'h0;
    end else begin
      counter_enable_bit <= next_counter_enable_bit;
      drift_correction_enable <= next_drift_correction_enable;
      tick_source_select <= next_tick_source_select;
      main_osc_prescale <= next_main_osc_prescale;
      drift_correction_value <= next_drift_correction_value;
      modulo <= next_modulo;
      count <= next_count;
      seconds <= next_seconds;
      minutes <= next_minutes;
      hours <= next_hours;
      ps_cnt <= next_ps_cnt;
      post_cnt <= next_post_cnt;
      counter_source_clock <= src_level;
      trim_reference_output <= next_trim_reference_output;
    end
  end

  // Write lock, status flags and request
  always_comb begin
    key = wdat[KEY_HI:KEY_LO];
    next_key_state = key_state;
    next_halt_in_debug = halt_in_debug;
    next_trim_output_select = trim_output_select;
    next_irq_en = irq_en;
    if (wr_hit(wr_go, idx, IDX_PROTECT)) begin
      next_halt_in_debug = wdat[BIT_HALT_DEBUG];
      next_trim_output_select = wdat[BIT_TRIM_SEL];
      case (key_state)
        LK_OPEN: next_key_state = (key == KEY_ARM) ? LK_ARMING : LK_OPEN;
        LK_ARMING: next_key_state = (key == KEY_ARM) ? LK_LOCKED : LK_OPEN;
        LK_LOCKED: next_key_state = (key == KEY_STEP0) ? LK_UN1 : LK_LOCKED;
        LK_UN1: next_key_state = (key == KEY_STEP1) ? LK_UN2 : LK_LOCKED;
        LK_UN2: next_key_state = (key == KEY_STEP2) ? LK_UN3 : LK_LOCKED;
        LK_UN3: next_key_state = (key == KEY_ARM) ? LK_OPEN : LK_LOCKED;
        default: next_key_state = LK_OPEN;
      endcase
    end
    if (wr_hit(wr_go, idx, IDX_IRQ_EN)) begin
      next_irq_en = wdat & EVENT_MASK;
    end
    events = 8'h00;
    events[BIT_HOUR] = hour_tick;
    events[BIT_MINUTE] = min_tick;
    events[BIT_SECOND] = sec_tick;
    events[BIT_DRIFT_EV] = drift_tick;
    events[BIT_TIMEBASE] = sec_tick;
    clear = wr_hit(wr_go, idx, IDX_STATUS) ? (wdat & EVENT_MASK) : 8'h00;
    // A new event beats a clear in the same cycle
    next_flags = (flags & ~clear) | events;
    next_irq_request = |(next_flags & irq_en);
  end

  always_ff @(posedge clk) begin
    if (any_rst) begin
      key_state <= LK_OPEN;
      halt_in_debug <= 1'h0;
      trim_output_select <= 1'h0;
      irq_en <= REG_RESET;
      flags <= REG_RESET;
      irq_request <= 1'h0;
    end else begin
      key_state <= next_key_state;
      halt_in_debug <= next_halt_in_debug;
      trim_output_select <= next_trim_output_select;
      irq_en <= next_irq_en;
      flags <= next_flags;
      irq_request <= next_irq_request;
    end
  end

  always_comb begin
    case (idx)
      IDX_ENABLE: rd_mux = {counter_enable_bit, 5'h00, drift_correction_enable, 1'h0};
      IDX_CLOCK_SEL: rd_mux = {tick_source_select, 2'h0, main_osc_prescale};
      IDX_PROTECT: rd_mux = {4'h0, halt_in_debug, 1'h0, trim_output_select, 1'h0};
      IDX_IRQ_EN: rd_mux = irq_en;
      IDX_STATUS: rd_mux = flags;
      IDX_DRIFT: rd_mux = drift_correction_value;
      IDX_MOD_HI: rd_mux = modulo[15:8];
      IDX_MOD_LO: rd_mux = modulo[7:0];
      IDX_CNT_HI: rd_mux = count[15:8];
      IDX_CNT_LO: rd_mux = count[7:0];
      IDX_SECONDS: rd_mux = {2'h0, seconds};
      IDX_MINUTES: rd_mux = {2'h0, minutes};
      IDX_HOURS: rd_mux = {3'h0, hours};
      default: rd_mux = 8'h00;
    endcase
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (any_rst);

  sequence s_last_second;
    sec_tick && seconds == SEC_LAST && !wr_hit(wr_go, idx, IDX_SECONDS);
  endsequence
  sequence s_rolled;
    seconds == 6'h00 && flags[BIT_MINUTE];
  endsequence
  property p_second_wrap;
    s_last_second |=> s_rolled;
  endproperty
  a_second_wrap: assert property (p_second_wrap) else $error("seconds did not wrap");

  property p_key_reads_zero;
    (bus_state == BUS_ACK && avs_read && idx == IDX_PROTECT) |-> avs_readdata[7:6] == 2'h0;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key bits read");

  property p_locked_write;
    (wr_hit(wr_go, idx, IDX_ENABLE) && key_state != LK_OPEN)
      |=> $stable(counter_enable_bit) && $stable(drift_correction_enable);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write taken");

  property p_open_write;
    (wr_hit(wr_go, idx, IDX_ENABLE) && key_state == LK_OPEN)
      |=> counter_enable_bit == $past(avs_writedata[BIT_COUNTER_ENABLE])
      && drift_correction_enable == $past(avs_writedata[BIT_DRIFT_ENABLE]);
  endproperty
  a_open_write: assert property (p_open_write) else $error("enable not written");

  property p_freeze;
    (debug_freeze && halt_in_debug) |=> $stable(count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved in freeze");

  // Both dividers must restart together after a main-source tick
  property p_main_path;
    (tick_source_select == SRC_MAIN && src_tick) |=> post_cnt == 5'h00 && ps_cnt == 4'h0;
  endproperty
  a_main_path: assert property (p_main_path) else $error("main divider slip");

  property p_rc_path;
    (tick_source_select == SRC_RC && rc_rise) |=> counter_source_clock;
  endproperty
  a_rc_path: assert property (p_rc_path) else $error("rc source not used");

  property p_second_irq;
    (sec_tick && irq_en[BIT_SECOND]) |=> irq_request && flags[BIT_SECOND] && count == 16'h0000;
  endproperty
  a_second_irq: assert property (p_second_irq) else $error("second event lost");

  property p_normal_reset;
    @(posedge clk) disable iff (!por_n)
      !rst_n |=> flags == REG_RESET && key_state == LK_OPEN && $stable(modulo);
  endproperty
  a_normal_reset: assert property (p_normal_reset) else $error("reset domain wrong");
endmodule : cal_rtc_core
`default_nettype wire

// >>> core/cal_pkg.sv
// Purpose: Shared constants and types for the calendar real-time counter
// Assumes: Registers are 8 bits wide, one per 32-bit Avalon word
// Notes: Register offsets are word indexes; byte address is four times the index
package cal_pkg;
  // Register indexes
  localparam logic [3:0] IDX_ENABLE = 4'h0;
  localparam logic [3:0] IDX_CLOCK_SEL = 4'h1;
  localparam logic [3:0] IDX_PROTECT = 4'h2;
  localparam logic [3:0] IDX_IRQ_EN = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_DRIFT = 4'h5;
  localparam logic [3:0] IDX_MOD_HI = 4'h6;
  localparam logic [3:0] IDX_MOD_LO = 4'h7;
  localparam logic [3:0] IDX_CNT_HI = 4'h8;
  localparam logic [3:0] IDX_CNT_LO = 4'h9;
  localparam logic [3:0] IDX_SECONDS = 4'hD;
  localparam logic [3:0] IDX_MINUTES = 4'hE;
  localparam logic [3:0] IDX_HOURS = 4'hF;
  // Field positions
  localparam int BIT_COUNTER_ENABLE = 7;
  localparam int BIT_DRIFT_ENABLE = 1;
  localparam int BIT_HALT_DEBUG = 3;
  localparam int BIT_TRIM_SEL = 1;
  localparam int KEY_HI = 7;
  localparam int KEY_LO = 6;
  localparam int BIT_HOUR = 5;
  localparam int BIT_MINUTE = 4;
  localparam int BIT_SECOND = 3;
  localparam int BIT_DRIFT_EV = 2;
  localparam int BIT_TIMEBASE = 0;
  // Writable bits of event enables and flags
  localparam logic [7:0] EVENT_MASK = 8'h3D;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Tick source codes
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  // Main crystal post divider: 1 MHz down to 31.25 kHz
  localparam logic [4:0] MAIN_POST_LAST = 5'h1F;
  // Calendar limits
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [5:0] HOUR_LAST = 6'h17;
  // Write lock key codes
  localparam logic [1:0] KEY_ARM = 2'h2;
  localparam logic [1:0] KEY_STEP0 = 2'h0;
  localparam logic [1:0] KEY_STEP1 = 2'h1;
  localparam logic [1:0] KEY_STEP2 = 2'h3;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } cal_bus_type;
  typedef enum logic [5:0] {
    LK_OPEN = 6'b000001,
    LK_ARMING = 6'b000010,
    LK_LOCKED = 6'b000100,
    LK_UN1 = 6'b001000,
    LK_UN2 = 6'b010000,
    LK_UN3 = 6'b100000
  } cal_lock_type;
endpackage : cal_pkg

// >>> core/cal_edge_sync.sv
// Purpose: Brings a foreign clock into clk as a level and a rising-edge pulse
// Assumes: Input toggles slower than half of clk
// Notes: Two flops before any logic; the edge detector compares the second with a third flop
`timescale 1ns/1ps
`default_nettype none
module cal_edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Foreign level
  input wire logic async_in,
  // Synchronised view
  output logic level,
  output logic rise
);
  logic meta;
  logic prev;
  logic next_meta;
  logic next_level;
  logic next_prev;

  always_comb begin
    next_meta = async_in;
    next_level = meta;
    next_prev = level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'h0;
      level <= 1'h0;
      prev <= 1'h0;
    end else begin
      meta <= next_meta;
      level <= next_level;
      prev <= next_prev;
    end
  end

  assign rise = level && !prev;
endmodule : cal_edge_sync
`default_nettype wire

// >>> dv/cal_rtc_core_bench.sv
// Purpose: Self-checking bench for the calendar real-time counter
// Assumes: Source clocks run free here; counter rates are judged over fixed windows
// Notes: Windows allow a tick of slack for main and slow, five for RC, since synchronisers add phase jitter
`timescale 1ns/1ps
`default_nettype none
module cal_rtc_core_bench;
  import cal_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic main_crystal_clock = 1'b0;
  logic slow_crystal_clock = 1'b0;
  logic internal_rc_clock = 1'b0;
  logic debug_freeze = 1'b0;
  logic counter_source_clock;
  logic trim_reference_output;
  logic irq_request;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] rd;

  always #25 clk = ~clk;
  // Offset keeps main crystal edges away from the sampling edge of clk
  initial begin
    #10;
    forever #125 main_crystal_clock = ~main_crystal_clock;
  end
  always #15259 slow_crystal_clock = ~slow_crystal_clock;
  always #500 internal_rc_clock = ~internal_rc_clock;

  cal_rtc_core DUT (
    .clk(clk), .rst_n(rst_n), .por_n(por_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_crystal_clock(main_crystal_clock), .slow_crystal_clock(slow_crystal_clock),
    .internal_rc_clock(internal_rc_clock), .debug_freeze(debug_freeze),
    .counter_source_clock(counter_source_clock),
    .trim_reference_output(trim_reference_output), .irq_request(irq_request)
  );

  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] i, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr

  task automatic rc(input string w, input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    check(w, rd, {24'h000000, e});
  endtask : rc

  task automatic pulse_rst();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : pulse_rst

  task automatic t_reset_values();
    for (int i = 0; i < 16; i++) begin
      rc("reset value", i[3:0], REG_RESET);
    end
  endtask : t_reset_values

  task automatic t_enable_bits();
    wr(IDX_ENABLE, 8'hFF);
    rc("enable bits", IDX_ENABLE, 8'h82);
    wr(IDX_ENABLE, 8'h00);
    rc("enable clear", IDX_ENABLE, 8'h00);
    // Lane 0 disabled: the write must be dropped
    avs_byteenable <= 4'hE;
    wr(IDX_ENABLE, 8'h80);
    avs_byteenable <= 4'hF;
    rc("byteenable", IDX_ENABLE, 8'h00);
    wr(IDX_CNT_LO, 8'h55);
    rc("count read only", IDX_CNT_LO, 8'h00);
    wr(4'hB, 8'hFF);
    rc("unmapped", 4'hB, 8'h00);
  endtask : t_enable_bits

  task automatic t_lock();
    wr(IDX_PROTECT, 8'h80);
    wr(IDX_PROTECT, 8'h80);
    wr(IDX_ENABLE, 8'h80);
    rc("locked write", IDX_ENABLE, 8'h00);
    rc("key reads zero", IDX_PROTECT, 8'h00);
    wr(IDX_PROTECT, 8'h00);
    wr(IDX_PROTECT, 8'h40);
    wr(IDX_PROTECT, 8'hC0);
    wr(IDX_PROTECT, 8'h80);
    wr(IDX_ENABLE, 8'h02);
    rc("unlocked write", IDX_ENABLE, 8'h02);
    wr(IDX_ENABLE, 8'h00);
    // Lock again with halt set, then a normal reset must reopen and clear it
    wr(IDX_MOD_LO, 8'hA5);
    wr(IDX_CLOCK_SEL, 8'h83);
    wr(IDX_IRQ_EN, EVENT_MASK);
    wr(IDX_PROTECT, 8'h88);
    wr(IDX_PROTECT, 8'h88);
    pulse_rst();
    rc("protect reset", IDX_PROTECT, 8'h00);
    rc("irq en reset", IDX_IRQ_EN, 8'h00);
    rc("modulo kept", IDX_MOD_LO, 8'hA5);
    rc("select kept", IDX_CLOCK_SEL, 8'h83);
    wr(IDX_ENABLE, 8'h80);
    rc("open after reset", IDX_ENABLE, 8'h80);
    wr(IDX_ENABLE, 8'h00);
  endtask : t_lock

  // Counts ticks of one source over a fixed window
  task automatic measure(input string w, input logic [7:0] sel, input int lo, input int hi);
    logic [7:0] c0;
    logic [7:0] dd;
    int sr;
    int tr;
    logic ls;
    logic lt;
    sr = 0;
    tr = 0;
    ls = counter_source_clock;
    lt = trim_reference_output;
    wr(IDX_CLOCK_SEL, sel);
    wr(IDX_MOD_HI, 8'hFF);
    wr(IDX_MOD_LO, 8'hFF);
    wr(IDX_ENABLE, 8'h80);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    c0 = rd[7:0];
    repeat (2600) begin
      @(posedge clk);
      if (counter_source_clock === 1'b1 && ls === 1'b0) sr++;
      if (trim_reference_output === 1'b1 && lt === 1'b0) tr++;
      ls = counter_source_clock;
      lt = trim_reference_output;
    end
    bus(1'b0, IDX_CNT_LO, 8'h00);
    dd = rd[7:0] - c0;
    check(w, 32'(dd >= lo && dd <= hi), 32'h1);
    check("trim follows", 32'(sr > 0 && (sr - tr) <= 1 && (tr - sr) <= 1), 32'h1);
    wr(IDX_ENABLE, 8'h00);
  endtask : measure

  task automatic t_calendar();
    int n;
    wr(IDX_CLOCK_SEL, 8'h80);
    wr(IDX_MOD_HI, 8'h00);
    wr(IDX_MOD_LO, 8'h20);
    wr(IDX_SECONDS, 8'h3B);
    wr(IDX_MINUTES, 8'h3B);
    wr(IDX_HOURS, 8'h17);
    wr(IDX_IRQ_EN, 8'h28);
    wr(IDX_STATUS, EVENT_MASK);
    wr(IDX_ENABLE, 8'h80);
    n = 0;
    do begin
      bus(1'b0, IDX_HOURS, 8'h00);
      n++;
    end while (rd[7:0] === 8'h17 && n < 400);
    wr(IDX_ENABLE, 8'h00);
    check("hours wrap", rd, 32'h0);
    rc("minutes wrap", IDX_MINUTES, 8'h00);
    rc("seconds wrap", IDX_SECONDS, 8'h00);
    rc("event flags", IDX_STATUS, 8'h39);
    check("irq raised", {31'h0, irq_request}, 32'h1);
    wr(IDX_IRQ_EN, 8'h00);
    // Request is registered from the old enables, so it drops one edge later
    @(posedge clk);
    check("irq masked", {31'h0, irq_request}, 32'h0);
    wr(IDX_STATUS, EVENT_MASK);
    rc("flags cleared", IDX_STATUS, 8'h00);
  endtask : t_calendar

  task automatic t_drift();
    int n;
    wr(IDX_DRIFT, 8'h10);
    wr(IDX_SECONDS, 8'h3B);
    wr(IDX_IRQ_EN, 8'h04);
    wr(IDX_ENABLE, 8'h82);
    n = 0;
    do begin
      bus(1'b0, IDX_STATUS, 8'h00);
      n++;
    end while (rd[BIT_DRIFT_EV] !== 1'b1 && n < 800);
    wr(IDX_ENABLE, 8'h00);
    check("drift event", {31'h0, rd[BIT_DRIFT_EV]}, 32'h1);
    check("drift irq", {31'h0, irq_request}, 32'h1);
    wr(IDX_STATUS, EVENT_MASK);
    wr(IDX_IRQ_EN, 8'h00);
  endtask : t_drift

  // RC source, modulo 0x20: one 1 Hz period is 33 ticks, about 660 cycles
  task automatic t_trim_hz();
    int tr;
    logic lt;
    tr = 0;
    wr(IDX_PROTECT, 8'h02);
    wr(IDX_ENABLE, 8'h80);
    lt = trim_reference_output;
    repeat (2000) begin
      @(posedge clk);
      if (trim_reference_output === 1'b1 && lt === 1'b0) tr++;
      lt = trim_reference_output;
    end
    wr(IDX_ENABLE, 8'h00);
    wr(IDX_PROTECT, 8'h00);
    check("trim one hertz", 32'(tr >= 2 && tr <= 4), 32'h1);
  endtask : t_trim_hz

  task automatic t_freeze();
    logic [7:0] c0;
    wr(IDX_CLOCK_SEL, 8'h80);
    wr(IDX_MOD_HI, 8'hFF);
    wr(IDX_PROTECT, 8'h08);
    wr(IDX_ENABLE, 8'h80);
    debug_freeze <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    c0 = rd[7:0];
    repeat (200) @(posedge clk);
    rc("halted", IDX_CNT_LO, c0);
    wr(IDX_PROTECT, 8'h00);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    c0 = rd[7:0];
    repeat (200) @(posedge clk);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    check("runs in freeze", 32'(rd[7:0] != c0), 32'h1);
    debug_freeze <= 1'b0;
    wr(IDX_ENABLE, 8'h00);
  endtask : t_freeze

  // Run is about 12k cycles; the limit leaves ample room
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_enable_bits();
    t_lock();
    measure("rc rate", 8'h80, 125, 135);
    measure("main rate", 8'h03, 3, 5);
    measure("slow rate", 8'h40, 3, 5);
    t_calendar();
    t_drift();
    t_trim_hz();
    t_freeze();
    wrap_up();
  end
endmodule : cal_rtc_core_bench
`default_nettype wire
